/* File: verilog/mfp_monitor.sv */
/*
  Motor fault protection monitor: watches bus voltage, rotor motion,
  phase current, torque current and temperature, latches fault flags,
  gates the power stage and reports the type of a lock, overload, overcurrent or over-temperature fault on the alarm pin.
  Assumes measurements arrive from logic on clk as unsigned magnitudes;
  the driver and memory fault pins are asynchronous and synchronised here.
*/
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module mfp_monitor #(
  parameter int unsigned HALF_SEC_CYCLES   = mfp_pkg::HALF_SEC_CYCLES,
  parameter int unsigned ALARM_SLOT_CYCLES = mfp_pkg::ALARM_SLOT_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic [15:0] bus_voltage,
  input  wire logic        speed_mode,
  input  wire logic        position_mode,
  input  wire logic [15:0] commanded_speed_rpm,
  input  wire logic        target_reached,
  input  wire logic [15:0] shaft_angle,
  input  wire logic [9:0]  phase_current,
  input  wire logic [11:0] torque_current,
  input  wire logic [11:0] torque_current_limit,
  input  wire logic [15:0] temperature,
  input  wire logic        driver_fault_input_b,
  input  wire logic        memory_fault_input,
  output logic             power_stage_enable,
  output logic             alarm_pin,
  output logic      [14:0] bus_voltage_ceiling,
  output logic             bus_voltage_ceiling_enable
);

  // software-visible settings
  logic [4:0]  retry_ctrl;
  logic [15:0] ovl_lock_ctrl;
  logic [15:0] bus_voltage_limit;
  logic [9:0]  overcurrent_threshold_value;
  logic [15:0] undervoltage_threshold_value;
  logic [15:0] overtemp_threshold;
  logic        undervoltage_enable;

  // fault state
  logic [mfp_pkg::FAULT_BITS-1:0] fault_status;
  logic [mfp_pkg::FAULT_BITS-1:0] fault_set;
  logic [mfp_pkg::FAULT_BITS-1:0] next_fault_status;
  logic shutdown;
  logic next_shutdown;
  logic trip;
  logic clear_cmd;

  // pin synchronisers
  logic drv_meta_b, drv_sync_b;
  logic mem_meta, mem_sync;

  // decoded fields
  logic       retry_en;
  logic [3:0] retry_time;
  logic       overload_en;
  logic [3:0] overload_time;
  logic       lock_en;
  logic [3:0] lock_time;

  // timers: cycles within a half-second and half-seconds elapsed
  logic [31:0] lock_cyc, ovl_cyc, rty_cyc;
  logic [4:0]  lock_halves, rty_halves;
  logic [5:0]  ovl_halves;
  logic        half_end_lock, half_end_ovl, half_end_rty;
  logic        lock_run, lock_done, lock_hit;
  logic        ovl_run, ovl_done;
  logic        rty_run, rty_done;

  logic [15:0] lock_start_angle;
  logic [15:0] angle_delta;
  logic [15:0] angle_mag;
  logic [13:0] torque_scaled;
  logic [13:0] torque_limit_scaled;

  mfp_alarm_if alm ();

  assign retry_en      = retry_ctrl[mfp_pkg::RETRY_EN_BIT];
  assign retry_time    = retry_ctrl[mfp_pkg::RETRY_TIME_LSB +: 4];
  assign overload_en   = ovl_lock_ctrl[mfp_pkg::OVERLOAD_EN_BIT];
  assign overload_time = ovl_lock_ctrl[mfp_pkg::OVERLOAD_TIME_LSB +: 4];
  assign lock_en       = ovl_lock_ctrl[mfp_pkg::LOCK_EN_BIT];
  assign lock_time     = ovl_lock_ctrl[mfp_pkg::LOCK_TIME_LSB +: 4];

  assign clear_cmd = reg_wr && reg_addr == mfp_pkg::ADDR_COMMAND
                     && reg_wdata == mfp_pkg::CMD_CLEAR_FAULT;

  // ceiling value and enable are only held and passed on
  assign bus_voltage_ceiling        = bus_voltage_limit[15:1];
  assign bus_voltage_ceiling_enable =
    bus_voltage_limit[mfp_pkg::CEILING_EN_BIT];
  assign power_stage_enable = !shutdown;

  // two-flop synchronisers for the companion chip pins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      drv_meta_b <= 1'b1;
      drv_sync_b <= 1'b1;
      mem_meta   <= 1'b0;
      mem_sync   <= 1'b0;
    end else begin
      drv_meta_b <= driver_fault_input_b;
      drv_sync_b <= drv_meta_b;
      mem_meta   <= memory_fault_input;
      mem_sync   <= mem_meta;
    end
  end

  // register writes; the status and command offsets hold no storage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      retry_ctrl                   <= mfp_pkg::RST_RETRY_CTRL;
      ovl_lock_ctrl                <= mfp_pkg::RST_OVL_LOCK;
      bus_voltage_limit            <= mfp_pkg::RST_BUS_V_LIM;
      overcurrent_threshold_value  <= mfp_pkg::RST_OC_THRESH;
      undervoltage_threshold_value <= mfp_pkg::RST_UV_THRESH;
      overtemp_threshold           <= mfp_pkg::RST_OT_THRESH;
      undervoltage_enable          <= mfp_pkg::RST_UV_ENABLE;
    end else if (reg_wr) begin
      if (reg_addr == mfp_pkg::ADDR_RETRY_CTRL) begin
        retry_ctrl <= reg_wdata[4:0];
      end else if (reg_addr == mfp_pkg::ADDR_OVL_LOCK_CTRL) begin
        // reserved bits stay zero
        ovl_lock_ctrl <= reg_wdata & 16'h1F1F;
      end else if (reg_addr == mfp_pkg::ADDR_BUS_V_LIMIT) begin
        bus_voltage_limit <= reg_wdata;
      end else if (reg_addr == mfp_pkg::ADDR_OC_THRESH) begin
        overcurrent_threshold_value <= reg_wdata[9:0];
      end else if (reg_addr == mfp_pkg::ADDR_UV_THRESH) begin
        undervoltage_threshold_value <= reg_wdata;
      end else if (reg_addr == mfp_pkg::ADDR_OT_THRESH) begin
        overtemp_threshold <= reg_wdata;
      end else if (reg_addr == mfp_pkg::ADDR_PROT_CTRL) begin
        undervoltage_enable <= reg_wdata[mfp_pkg::UV_EN_BIT];
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
    end else if (!reg_rd) begin
      reg_rdata <= 16'h0000;
    end else if (reg_addr == mfp_pkg::ADDR_FAULT_STATUS) begin
      reg_rdata <= {9'h000, fault_status};
    end else if (reg_addr == mfp_pkg::ADDR_RETRY_CTRL) begin
      reg_rdata <= {11'h000, retry_ctrl};
    end else if (reg_addr == mfp_pkg::ADDR_OVL_LOCK_CTRL) begin
      reg_rdata <= ovl_lock_ctrl;
    end else if (reg_addr == mfp_pkg::ADDR_BUS_V_LIMIT) begin
      reg_rdata <= bus_voltage_limit;
    end else if (reg_addr == mfp_pkg::ADDR_OC_THRESH) begin
      reg_rdata <= {6'h00, overcurrent_threshold_value};
    end else if (reg_addr == mfp_pkg::ADDR_UV_THRESH) begin
      reg_rdata <= undervoltage_threshold_value;
    end else if (reg_addr == mfp_pkg::ADDR_OT_THRESH) begin
      reg_rdata <= overtemp_threshold;
    end else if (reg_addr == mfp_pkg::ADDR_PROT_CTRL) begin
      reg_rdata <= {15'h0000, undervoltage_enable};
    end else if (reg_addr == mfp_pkg::ADDR_PROT_STATE) begin
      reg_rdata <= {15'h0000, shutdown};
    end else begin
      reg_rdata <= 16'h0000; // command and unmapped offsets read zero
    end
  end

  // rotor-lock arming: only while driving and asked to move
  assign lock_run = lock_en && !shutdown
    && ((speed_mode
         && commanded_speed_rpm > mfp_pkg::LOCK_MIN_SPEED_RPM)
        || (position_mode && !target_reached));

  assign half_end_lock = (lock_cyc == 32'(HALF_SEC_CYCLES - 1));
  assign lock_done = (lock_halves == {1'b0, lock_time} + 5'h01);

  // a window restarts whenever it ends, so a turn slower than 5 degrees per window still trips
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_cyc    <= 32'h0000_0000;
      lock_halves <= 5'h00;
    end else if (!lock_run || lock_done) begin
      lock_cyc    <= 32'h0000_0000;
      lock_halves <= 5'h00;
    end else if (half_end_lock) begin
      lock_cyc    <= 32'h0000_0000;
      lock_halves <= lock_halves + 5'h01;
    end else begin
      lock_cyc <= lock_cyc + 32'h0000_0001;
    end
  end

  // reference angle captured at every window start
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_start_angle <= 16'h0000;
    end else if (!lock_run || lock_done) begin
      lock_start_angle <= shaft_angle;
    end
  end

  // wrap-safe angular distance, in either direction
  assign angle_delta = shaft_angle - lock_start_angle;
  assign angle_mag   = angle_delta[15] ? 16'(-angle_delta) : angle_delta;
  assign lock_hit    = lock_run && lock_done
                       && angle_mag < mfp_pkg::LOCK_ANGLE_LSB;

  // overload: 4*iq against 3*limit avoids a divider
  assign torque_scaled = {torque_current, 2'b00};
  assign torque_limit_scaled =
    14'(torque_current_limit) * mfp_pkg::OVL_RATIO_NUM;
  assign ovl_run = overload_en && !shutdown
                   && torque_scaled > torque_limit_scaled;
  assign half_end_ovl = (ovl_cyc == 32'(HALF_SEC_CYCLES - 1));
  assign ovl_done =
    (ovl_halves == {5'(overload_time) + 5'h01, 1'b0});

  // any dip below the limit restarts the whole window
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ovl_cyc    <= 32'h0000_0000;
      ovl_halves <= 6'h00;
    end else if (!ovl_run || ovl_done) begin
      ovl_cyc    <= 32'h0000_0000;
      ovl_halves <= 6'h00;
    end else if (half_end_ovl) begin
      ovl_cyc    <= 32'h0000_0000;
      ovl_halves <= ovl_halves + 6'h01;
    end else begin
      ovl_cyc <= ovl_cyc + 32'h0000_0001;
    end
  end

  // auto-retry timer runs only while shut down with retry enabled
  assign rty_run      = shutdown && retry_en;
  assign half_end_rty = (rty_cyc == 32'(HALF_SEC_CYCLES - 1));
  assign rty_done     = (rty_halves == {1'b0, retry_time} + 5'h01);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rty_cyc    <= 32'h0000_0000;
      rty_halves <= 5'h00;
    end else if (!rty_run || rty_done) begin
      rty_cyc    <= 32'h0000_0000;
      rty_halves <= 5'h00;
    end else if (half_end_rty) begin
      rty_cyc    <= 32'h0000_0000;
      rty_halves <= rty_halves + 5'h01;
    end else begin
      rty_cyc <= rty_cyc + 32'h0000_0001;
    end
  end

  // fault detection, one set term per status bit
  always_comb begin
    fault_set = '0;
    fault_set[mfp_pkg::FS_UNDERVOLT] = undervoltage_enable
      && bus_voltage < undervoltage_threshold_value;
    fault_set[mfp_pkg::FS_OVERTEMP] =
      temperature > overtemp_threshold;
    fault_set[mfp_pkg::FS_OVERLOAD] = ovl_run && ovl_done;
    fault_set[mfp_pkg::FS_LOCK] = lock_hit;
    fault_set[mfp_pkg::FS_OVERCURRENT] =
      phase_current > overcurrent_threshold_value;
    fault_set[mfp_pkg::FS_DRIVER] = !drv_sync_b;
    fault_set[mfp_pkg::FS_MEMORY] = mem_sync;
  end

  // severe faults trip the stage; overtemp, undervoltage and memory faults only flag
  assign trip = fault_set[mfp_pkg::FS_OVERCURRENT]
             || fault_set[mfp_pkg::FS_OVERLOAD]
             || fault_set[mfp_pkg::FS_LOCK]
             || fault_set[mfp_pkg::FS_DRIVER];

  // a fault arriving with the clear still lands
  assign next_fault_status =
    (fault_status & ~{mfp_pkg::FAULT_BITS{clear_cmd}}) | fault_set;
  assign next_shutdown =
    trip || (shutdown && !clear_cmd && !rty_done);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_status <= '0;
    end else begin
      fault_status <= next_fault_status;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shutdown <= 1'b0;
    end else begin
      shutdown <= next_shutdown;
    end
  end

  // alarm burst request: highest-priority latched fault, repeated
  always_comb begin
    alm.start = !alm.busy;
    if (fault_status[mfp_pkg::FS_OVERCURRENT]) begin
      alm.count = mfp_pkg::ALARM_N_OVERCURRENT;
    end else if (fault_status[mfp_pkg::FS_LOCK]) begin
      alm.count = mfp_pkg::ALARM_N_LOCK;
    end else if (fault_status[mfp_pkg::FS_OVERLOAD]) begin
      alm.count = mfp_pkg::ALARM_N_OVERLOAD;
    end else if (fault_status[mfp_pkg::FS_OVERTEMP]) begin
      alm.count = mfp_pkg::ALARM_N_OVERTEMP;
    end else begin
      alm.count = 3'h0; // no start taken with a zero count
    end
  end

  mfp_alarm #(
    .SLOT_CYCLES (ALARM_SLOT_CYCLES)
  ) u_alarm (
    .clk       (clk),
    .rst_b     (rst_b),
    .alm       (alm.gen),
    .alarm_pin (alarm_pin)
  );

endmodule

`default_nettype wire

/* File: verilog/mfp_pkg.sv */
/*
  Constants shared by the motor fault protection monitor: register offsets,
  field positions, reset values, timing counts and the alarm state type.
  Assumes a 50 MHz system clock and a 16-bit register port.
*/
`default_nettype none

package mfp_pkg;

  // clock and timing, figures in their own units first
  localparam int CLK_PERIOD_NS   = 20;
  localparam int HALF_SEC_MS     = 500;
  localparam int HALF_SEC_CYCLES = HALF_SEC_MS * 1000000 / CLK_PERIOD_NS;
  localparam int ALARM_SLOT_MS   = 100;
  localparam int ALARM_SLOT_CYCLES =
    ALARM_SLOT_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [3:0] ALARM_GAP_SLOTS = 4'h8;

  // register offsets on the 8-bit address port
  localparam logic [7:0] ADDR_FAULT_STATUS   = 8'h53;
  localparam logic [7:0] ADDR_RETRY_CTRL     = 8'h54;
  localparam logic [7:0] ADDR_OVL_LOCK_CTRL  = 8'h55;
  localparam logic [7:0] ADDR_BUS_V_LIMIT    = 8'h56;
  localparam logic [7:0] ADDR_OC_THRESH      = 8'h5A;
  localparam logic [7:0] ADDR_UV_THRESH      = 8'h5B;
  localparam logic [7:0] ADDR_OT_THRESH      = 8'h6B;
  localparam logic [7:0] ADDR_PROT_CTRL      = 8'h70;
  localparam logic [7:0] ADDR_PROT_STATE     = 8'h71;
  localparam logic [7:0] ADDR_COMMAND        = 8'h72;
  localparam logic [15:0] CMD_CLEAR_FAULT    = 16'h0000;

  // fault status bit positions
  localparam int FAULT_BITS     = 7;
  localparam int FS_UNDERVOLT   = 6;
  localparam int FS_OVERTEMP    = 5;
  localparam int FS_OVERLOAD    = 4;
  localparam int FS_LOCK        = 3;
  localparam int FS_OVERCURRENT = 2;
  localparam int FS_DRIVER      = 1;
  localparam int FS_MEMORY      = 0;

  // control field positions
  localparam int RETRY_EN_BIT     = 4;
  localparam int RETRY_TIME_LSB   = 0;
  localparam int OVERLOAD_EN_BIT  = 12;
  localparam int OVERLOAD_TIME_LSB = 8;
  localparam int LOCK_EN_BIT      = 4;
  localparam int LOCK_TIME_LSB    = 0;
  localparam int CEILING_EN_BIT   = 0;
  localparam int UV_EN_BIT        = 0;

  // reset values
  localparam logic [4:0]  RST_RETRY_CTRL = 5'h02;
  localparam logic [15:0] RST_OVL_LOCK   = 16'h0000;
  localparam logic [15:0] RST_BUS_V_LIM  = 16'h0000;
  localparam logic [9:0]  RST_OC_THRESH  = 10'h3FF;
  localparam logic [15:0] RST_UV_THRESH  = 16'h0000;
  localparam logic [15:0] RST_OT_THRESH  = 16'h0055;
  localparam logic        RST_UV_ENABLE  = 1'b0;

  // rotor-lock limits: speed in rpm, angle 1 LSB = 360/65536 degree
  localparam logic [15:0] LOCK_MIN_SPEED_RPM = 16'h0014;
  localparam int LOCK_ANGLE_DEG = 5;
  localparam logic [15:0] LOCK_ANGLE_LSB =
    16'((LOCK_ANGLE_DEG * 65536 + 359) / 360);

  // overload trips above 3/4 of the torque current limit
  localparam logic [13:0] OVL_RATIO_NUM = 14'h0003;
  localparam int          OVL_RATIO_SHIFT = 2;

  // alarm pulse counts per fault type
  localparam logic [2:0] ALARM_N_OVERCURRENT = 3'h3;
  localparam logic [2:0] ALARM_N_LOCK        = 3'h4;
  localparam logic [2:0] ALARM_N_OVERLOAD    = 3'h5;
  localparam logic [2:0] ALARM_N_OVERTEMP    = 3'h6;

  typedef enum logic [1:0] {
    MFP_AL_IDLE,
    MFP_AL_HIGH,
    MFP_AL_LOW,
    MFP_AL_GAP
  } mfp_alarm_state_t;

endpackage

`default_nettype wire

/* File: verilog/mfp_alarm_if.sv */
/*
  Interface between the fault monitor and its alarm pulse generator.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface mfp_alarm_if;
  logic       start;
  logic [2:0] count;
  logic       busy;

  modport ctrl (output start, output count, input busy);
  modport gen  (input start, input count, output busy);
endinterface

`default_nettype wire

/* File: verilog/mfp_alarm.sv */
/*
  Alarm pin pulse generator: plays a burst of count pulses, each one slot
  high and one slot low, then a quiet gap, and drops busy.
  Assumes start is a level from logic on the same clock, sampled only while idle.
*/
`timescale 1ns/1ps
`default_nettype none

module mfp_alarm #(
  parameter int unsigned SLOT_CYCLES = mfp_pkg::ALARM_SLOT_CYCLES
) (
  input  wire logic   clk,
  input  wire logic   rst_b,
  mfp_alarm_if.gen    alm,
  output logic        alarm_pin
);

  mfp_pkg::mfp_alarm_state_t state;
  logic [31:0] slot_cnt;
  logic [2:0]  pulses_left;
  logic [3:0]  gap_left;
  logic        slot_end;

  assign slot_end = (slot_cnt == 32'(SLOT_CYCLES - 1));
  assign alm.busy = (state != mfp_pkg::MFP_AL_IDLE);

  // slot timer restarts at every burst start and every slot end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      slot_cnt <= 32'h0000_0000;
    end else if (state == mfp_pkg::MFP_AL_IDLE || slot_end) begin
      slot_cnt <= 32'h0000_0000;
    end else begin
      slot_cnt <= slot_cnt + 32'h0000_0001;
    end
  end

  // burst sequencer; the gap keeps bursts apart so they can be counted
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state       <= mfp_pkg::MFP_AL_IDLE;
      pulses_left <= 3'h0;
      gap_left    <= 4'h0;
      alarm_pin   <= 1'b0;
    end else begin
      case (state)
        mfp_pkg::MFP_AL_IDLE: begin
          if (alm.start && alm.count != 3'h0) begin
            state       <= mfp_pkg::MFP_AL_HIGH;
            pulses_left <= alm.count;
            alarm_pin   <= 1'b1;
          end
        end
        mfp_pkg::MFP_AL_HIGH: begin
          if (slot_end) begin
            state       <= mfp_pkg::MFP_AL_LOW;
            pulses_left <= pulses_left - 3'h1;
            alarm_pin   <= 1'b0;
          end
        end
        mfp_pkg::MFP_AL_LOW: begin
          if (slot_end) begin
            if (pulses_left == 3'h0) begin
              state    <= mfp_pkg::MFP_AL_GAP;
              gap_left <= mfp_pkg::ALARM_GAP_SLOTS;
            end else begin
              state     <= mfp_pkg::MFP_AL_HIGH;
              alarm_pin <= 1'b1;
            end
          end
        end
        mfp_pkg::MFP_AL_GAP: begin
          if (slot_end) begin
            if (gap_left == 4'h1) begin
              state <= mfp_pkg::MFP_AL_IDLE;
            end
            gap_left <= gap_left - 4'h1;
          end
        end
        default: state <= mfp_pkg::MFP_AL_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

/* File: test/mfp_monitor_checker.sv */
/* port checker for the fault monitor
   assumes it is bound onto mfp_monitor */
`timescale 1ns/1ps
`default_nettype none
module mfp_checker (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [9:0]  phase_current,
  input wire logic        driver_fault_input_b,
  input wire logic        power_stage_enable,
  input wire logic [14:0] bus_voltage_ceiling,
  input wire logic        bus_voltage_ceiling_enable
);
  logic [9:0] oc_thr;
  logic       rty_en;
  logic [1:0] det_en;
  logic       clr;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // clear command decode
  assign clr = reg_wr && reg_addr == 8'h72 && reg_wdata == 16'h0000;
  // shadow of the fields that gate trips and release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      oc_thr <= 10'h3FF;
      rty_en <= 1'b0;
      det_en <= 2'h0;
    end else if (reg_wr) begin
      if (reg_addr == 8'h5A) oc_thr <= reg_wdata[9:0];
      if (reg_addr == 8'h54) rty_en <= reg_wdata[4];
      if (reg_addr == 8'h55) det_en <= {reg_wdata[12], reg_wdata[4]};
    end
  end
  rd_quiet_a:
    assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside read");
  ceil_write_a:
    assert property (reg_wr && reg_addr == 8'h56 |=>
      {bus_voltage_ceiling, bus_voltage_ceiling_enable} == $past(reg_wdata))
    else $error("ceiling outputs differ from write");
  rw_echo_a:
    assert property (reg_wr && (reg_addr == 8'h5B || reg_addr == 8'h6B)
      ##1 reg_rd && reg_addr == $past(reg_addr)
      |=> reg_rdata == $past(reg_wdata, 2))
    else $error("threshold read back wrong");
  oc_trip_a:
    assert property (phase_current > oc_thr |-> ##[1:3] !power_stage_enable)
    else $error("stage not off after overcurrent");
  drv_trip_a:
    assert property (!driver_fault_input_b [*3] |=> !power_stage_enable)
    else $error("stage not off after driver fault");
  hold_off_a:
    assert property (!power_stage_enable && !clr && !rty_en
      |=> !power_stage_enable)
    else $error("stage released without clear");
  clear_run_a:
    assert property (clr && det_en == 2'h0 && phase_current <= oc_thr &&
      driver_fault_input_b && $past(driver_fault_input_b) &&
      $past(driver_fault_input_b, 2) |=> power_stage_enable)
    else $error("clear did not restart stage");
  cmd_read_a:
    assert property (reg_rd && reg_addr == 8'h72 |=> reg_rdata == 16'h0000)
    else $error("command register read not zero");
endmodule
bind mfp_monitor mfp_checker chk (
  .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .phase_current(phase_current),
  .driver_fault_input_b(driver_fault_input_b),
  .power_stage_enable(power_stage_enable),
  .bus_voltage_ceiling(bus_voltage_ceiling),
  .bus_voltage_ceiling_enable(bus_voltage_ceiling_enable)
);
`default_nettype wire

/* File: test/mfp_host_model.sv */
/* host side watcher that counts alarm pulses per burst
   assumes the alarm pin idles low between bursts */
`timescale 1ns/1ps
`default_nettype none
module mfp_host_model #(
  parameter int unsigned SLOT = 2
) (
  input  wire logic  clk,
  input  wire logic  rst_b,
  input  wire logic  alarm_pin,
  output logic [3:0] burst_n,
  output logic [7:0] burst_seq
);
  logic [3:0] cnt;
  logic [7:0] low_run;
  logic       pin_q;
  // a burst closes only after a quiet spell longer than a pulse gap
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {cnt, low_run, pin_q, burst_n, burst_seq} <= '0;
    end else begin
      pin_q <= alarm_pin;
      low_run <= alarm_pin ? 8'h00 : low_run + 8'h01;
      if (alarm_pin && !pin_q) cnt <= cnt + 4'h1;
      if (low_run == 8'(4 * SLOT) && cnt != 4'h0) begin
        burst_n <= cnt;
        burst_seq <= burst_seq + 8'h01;
        cnt <= 4'h0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: test/mfp_monitor_tb_top.sv */
/* self-checking bench for the fault monitor
   assumes short timing parameters: half second 8, alarm slot 2 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin \
  total_checks++; \
  if ((got) !== (ex)) begin \
    bad_count++; \
    $display("BAD %s exp %h got %h", nm, ex, got); \
  end \
end
module mfp_monitor_tb_top;
  logic clk = 1'b0, rst_b, reg_wr, reg_rd, speed_mode, position_mode;
  logic target_reached, driver_fault_input_b, memory_fault_input;
  logic power_stage_enable, alarm_pin, bus_voltage_ceiling_enable;
  logic [7:0] reg_addr, burst_seq;
  logic [15:0] reg_wdata, reg_rdata, bus_voltage, commanded_speed_rpm;
  logic [15:0] shaft_angle, temperature, v;
  logic [14:0] bus_voltage_ceiling;
  logic [11:0] torque_current, torque_current_limit;
  logic [9:0] phase_current;
  logic [3:0] burst_n;
  int bad_count, total_checks, cycles;
  logic [7:0] ra [8] = '{8'h53, 8'h54, 8'h55, 8'h56, 8'h5A, 8'h5B,
                         8'h6B, 8'h72};
  logic [15:0] rv [8] = '{16'h0000, 16'h0002, 16'h0000, 16'h0000,
                          16'h03FF, 16'h0000, 16'h0055, 16'h0000};
  mfp_monitor #(.HALF_SEC_CYCLES(8), .ALARM_SLOT_CYCLES(2)) uut (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bus_voltage(bus_voltage), .speed_mode(speed_mode),
    .position_mode(position_mode), .target_reached(target_reached),
    .commanded_speed_rpm(commanded_speed_rpm), .shaft_angle(shaft_angle),
    .phase_current(phase_current), .torque_current(torque_current),
    .torque_current_limit(torque_current_limit), .temperature(temperature),
    .driver_fault_input_b(driver_fault_input_b),
    .memory_fault_input(memory_fault_input),
    .power_stage_enable(power_stage_enable), .alarm_pin(alarm_pin),
    .bus_voltage_ceiling(bus_voltage_ceiling),
    .bus_voltage_ceiling_enable(bus_voltage_ceiling_enable));
  mfp_host_model #(.SLOT(2)) host (.clk(clk), .rst_b(rst_b),
    .alarm_pin(alarm_pin), .burst_n(burst_n), .burst_seq(burst_seq));
  // 50 MHz clock
  always #10 clk = ~clk;
  task automatic finish_test();
    if (bad_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // hang guard above the planned run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] ex);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 `CHK("reg", ex, reg_rdata)
    @(posedge clk);
  endtask
  task automatic burst(input logic [3:0] ex);
    logic [7:0] s;
    s = burst_seq;
    for (int i = 0; i < 300 && burst_seq == s; i++) @(posedge clk);
    `CHK("alarm", ex, burst_n & {4{burst_seq != s}})
  endtask
  // clear, then let any burst in flight run out
  task automatic clr_all();
    cyc(1);
    wr(8'h72, 16'h0000);
    cyc(48);
  endtask
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, rst_b} = '0;
    {speed_mode, position_mode, target_reached} = 3'b001;
    {driver_fault_input_b, memory_fault_input} = 2'b10;
    {bus_voltage, commanded_speed_rpm, shaft_angle, temperature} = '0;
    {phase_current, torque_current, torque_current_limit} = '0;
    void'($urandom(28));
    cyc(20);
    rst_b <= 1'b1;
    @(posedge clk);
    foreach (ra[i]) rdc(ra[i], rv[i]);
    wr(8'h53, 16'hFFFF);
    rdc(8'h53, 16'h0000);
    for (int i = 3; i < 15; i++) begin
      v = 16'($urandom);
      wr(ra[i % 4 + 3], v);
      rdc(ra[i % 4 + 3], i % 4 == 1 ? v & 16'h03FF : v);
    end
    wr(8'h56, v);
    rdc(8'h56, v);
    `CHK("vl", v, {bus_voltage_ceiling, bus_voltage_ceiling_enable})
    // under-voltage off then on
    wr(8'h5B, 16'h1000);
    bus_voltage <= 16'h0FFF;
    cyc(4);
    rdc(8'h53, 16'h0000);
    wr(8'h70, 16'h0001);
    cyc(2);
    rdc(8'h53, 16'h0040);
    bus_voltage <= 16'h8000;
    wr(8'h70, 16'h0000);
    clr_all();
    // over-temperature keeps the stage running
    wr(8'h6B, 16'h0055);
    temperature <= 16'h0056;
    burst(4'h6);
    rdc(8'h53, 16'h0020);
    `CHK("stage", 1'b1, power_stage_enable)
    temperature <= 16'h0055;
    clr_all();
    // overcurrent: latch-off, set beats clear, then retry
    v = 16'($urandom_range(1022, 1));
    wr(8'h5A, v);
    phase_current <= v[9:0] + 10'h001;
    burst(4'h3);
    wr(8'h72, 16'h0000);
    rdc(8'h53, 16'h0004);
    `CHK("stage", 1'b0, power_stage_enable)
    phase_current <= v[9:0];
    clr_all();
    rdc(8'h53, 16'h0000);
    `CHK("stage", 1'b1, power_stage_enable)
    wr(8'h54, 16'h0010);
    phase_current <= v[9:0] + 10'h001;
    cyc(3);
    phase_current <= v[9:0];
    `CHK("stage", 1'b0, power_stage_enable)
    cyc(14);
    `CHK("stage", 1'b1, power_stage_enable)
    rdc(8'h53, 16'h0004);
    wr(8'h54, 16'h0000);
    clr_all();
    // rotor lock in speed mode, then in position mode
    for (int m = 0; m < 2; m++) begin
      {speed_mode, position_mode} <= m ? 2'b01 : 2'b10;
      commanded_speed_rpm <= 16'h0015;
      target_reached <= 1'b0;
      shaft_angle <= 16'($urandom);
      cyc(24);
      rdc(8'h53, 16'h0000);
      wr(8'h55, 16'h0010);
      burst(4'h4);
      rdc(8'h53, 16'h0008);
      wr(8'h55, 16'h0000);
      {speed_mode, position_mode} <= 2'b00;
      clr_all();
    end
    // overload at the exact three-quarter boundary, then over it
    torque_current_limit <= 12'h190;
    torque_current <= 12'h12C;
    wr(8'h55, 16'h1000);
    cyc(40);
    rdc(8'h53, 16'h0000);
    torque_current <= 12'h12D;
    burst(4'h5);
    rdc(8'h53, 16'h0010);
    torque_current <= 12'h12C;
    wr(8'h55, 16'h0000);
    clr_all();
    // driver fault and memory fault pins
    driver_fault_input_b <= 1'b0;
    memory_fault_input <= 1'b1;
    cyc(5);
    rdc(8'h53, 16'h0003);
    `CHK("stage", 1'b0, power_stage_enable)
    {driver_fault_input_b, memory_fault_input} <= 2'b10;
    cyc(3);
    clr_all();
    rdc(8'h53, 16'h0000);
    finish_test();
  end
endmodule
`default_nettype wire
